// ### rtl/sarrd_pkg.sv
package sarrd_pkg;
   // converter resolution and frame layout
   localparam int RES_BITS = 12;
   localparam int LEAD_ZEROS = 4;
   localparam int FRAME_BITS = LEAD_ZEROS + RES_BITS;
   localparam int CNT_W = 5;
   localparam int BIT_W = 4;
   localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;
   localparam logic [CNT_W-1:0] ZERO_LEN = 5'h04;
   // first serial clock rising edge that decides a result bit
   localparam logic [CNT_W-1:0] SAR_FIRST_RISE = 5'h03;
   localparam logic [BIT_W-1:0] SAR_MSB = 4'hb;
   localparam logic [BIT_W-1:0] SAR_LSB = 4'h0;
   localparam logic [RES_BITS-1:0] CODE_ZERO = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [BIT_W-1:0] BIT_ONE = 4'h1;

   typedef enum logic [1:0] {
      SARRD_IDLE = 2'b00,
      SARRD_CONV = 2'b01,
      SARRD_READ = 2'b11,
      SARRD_DONE = 2'b10
   } sarrd_state_t;
endpackage

// ### rtl/sarrd_top.sv
`timescale 1ns/1ps
// Functional notes
// RQ1 - A falling frame select (active low) from the host samples the input and starts a conversion.
// RQ2 - The frame select also frames the transfer; result bits are driven only while it is low.
// RQ3 - The serial result output advances one bit on every falling serial clock edge.
// RQ4 - Each frame carries four zero bits followed by the twelve result bits, sixteen in all.
// RQ5 - The twelve result bits follow the zeros straight away, most significant bit first.
// RQ6 - The result is twos complement, so negative differential inputs set the top bit.
// RQ7 - The host serial clock paces the approximation steps as well as the read-out.
// RQ8 - Full scale positive is 0111..1 reached from 0111..0, most negative is 1000..0.
// RQ9 - Zero differential input sits at the step from all ones to all zeros.
// RQ10 - A conversion takes sixteen serial clock periods, which the host supplies per frame.
// RQ11 - The host keeps the serial clock between 10 kHz and 10 MHz.
// RQ12 - The host waits at least 60 ns after a read before lowering frame select again.
// RQ13 - After the sixteenth bit the host raises frame select and the output is released.
module sarrd_top
   import sarrd_pkg::*;
#(
   parameter int RES_W = RES_BITS
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic frame_sel_n,
   input wire logic serial_clk,
   input wire logic comp_above,
   output logic [RES_W-1:0] dac_trial_code,
   output logic track_hold,
   output logic serial_result_out,
   output logic serial_result_oe,
   output logic [RES_W-1:0] conv_result,
   output logic conv_done
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // offset binary sar code to twos complement
   function automatic logic [RES_W-1:0] to_twos(input logic [RES_W-1:0] code);
      to_twos = {~code[RES_W-1], code[RES_W-2:0]};
   endfunction

   function automatic logic [RES_W-1:0] bit_mask(input logic [BIT_W-1:0] idx);
      bit_mask = {{(RES_W-1){1'b0}}, 1'b1} << idx;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [1:0] fs_sync_q;
   logic [1:0] sck_sync_q;
   logic [1:0] cmp_sync_q;
   logic fs_prev_q;
   logic sck_prev_q;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fs_sync_q <= 2'b11;
         sck_sync_q <= 2'b11;
         cmp_sync_q <= 2'b00;
         fs_prev_q <= 1'b1;
         sck_prev_q <= 1'b1;
      end
      else
      begin
         fs_sync_q <= {fs_sync_q[0], frame_sel_n};
         sck_sync_q <= {sck_sync_q[0], serial_clk};
         cmp_sync_q <= {cmp_sync_q[0], comp_above};
         fs_prev_q <= fs_sync_q[1];
         sck_prev_q <= sck_sync_q[1];
      end
   end

   logic fs_fall;
   logic fs_high;
   logic sck_fall;
   logic sck_rise;

   assign fs_fall = fs_prev_q & ~fs_sync_q[1]; // see RQ1
   assign fs_high = fs_sync_q[1]; // see RQ2
   assign sck_fall = sck_prev_q & ~sck_sync_q[1];
   assign sck_rise = ~sck_prev_q & sck_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////////
   // frame state

   sarrd_state_t state_q;
   logic [CNT_W-1:0] fall_cnt_q;
   logic [CNT_W-1:0] rise_cnt_q;
   logic [BIT_W-1:0] sar_bit_q;
   logic [RES_W-1:0] sar_code_q;
   logic last_decide;
   logic decide;

   assign decide = (state_q == SARRD_CONV) && sck_rise && !fs_high
      && (rise_cnt_q >= SAR_FIRST_RISE - CNT_ONE); // see RQ7
   assign last_decide = decide && (sar_bit_q == SAR_LSB);

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= SARRD_IDLE;
      end
      else if (fs_high)
      begin
         state_q <= SARRD_IDLE; // see RQ2
      end
      else
      begin
         unique case (state_q)
            SARRD_IDLE:
            begin
               if (fs_fall)
               begin
                  state_q <= SARRD_CONV; // see RQ1
               end
            end
            SARRD_CONV:
            begin
               if (last_decide)
               begin
                  state_q <= SARRD_READ;
               end
            end
            SARRD_READ:
            begin
               if (sck_fall && fall_cnt_q == FRAME_LEN - CNT_ONE)
               begin
                  state_q <= SARRD_DONE; // see RQ10
               end
            end
            SARRD_DONE:
            begin
               state_q <= SARRD_DONE;
            end
         endcase
      end
   end

   // serial clock edge counters within a frame
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fall_cnt_q <= CNT_ZERO;
         rise_cnt_q <= CNT_ZERO;
      end
      else if (state_q == SARRD_IDLE)
      begin
         fall_cnt_q <= CNT_ZERO;
         rise_cnt_q <= CNT_ZERO;
      end
      else
      begin
         if (sck_fall && fall_cnt_q != FRAME_LEN)
         begin
            fall_cnt_q <= fall_cnt_q + CNT_ONE; // see RQ3
         end
         if (sck_rise && rise_cnt_q != FRAME_LEN)
         begin
            rise_cnt_q <= rise_cnt_q + CNT_ONE; // see RQ7
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // successive approximation

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sar_bit_q <= SAR_MSB;
         sar_code_q <= CODE_ZERO;
      end
      else if (state_q == SARRD_IDLE)
      begin
         sar_bit_q <= SAR_MSB;
         sar_code_q <= CODE_ZERO;
      end
      else if (decide)
      begin
         // keep the trial bit only when the input lies above the trial level
         if (cmp_sync_q[1])
         begin
            sar_code_q <= sar_code_q | bit_mask(sar_bit_q); // see RQ7
         end
         if (!last_decide)
         begin
            sar_bit_q <= sar_bit_q - BIT_ONE;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dac_trial_code <= CODE_ZERO;
         track_hold <= 1'b0;
      end
      else
      begin
         dac_trial_code <= (state_q == SARRD_CONV) ? (sar_code_q | bit_mask(sar_bit_q))
            : sar_code_q;
         track_hold <= (state_q == SARRD_CONV); // see RQ1
      end
   end

   // result capture
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         conv_result <= CODE_ZERO;
         conv_done <= 1'b0;
      end
      else
      begin
         conv_done <= 1'b0;
         if (last_decide)
         begin
            // offset code 0x800 maps to 0x000: midscale and full-scale ends
            conv_result <= to_twos(sar_code_q | (cmp_sync_q[1] ? bit_mask(SAR_LSB)
               : CODE_ZERO)); // see RQ6, RQ8, RQ9
            conv_done <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // serial read-out

   logic [RES_W-1:0] out_code;
   logic [CNT_W-1:0] next_pos;
   logic [CNT_W-1:0] res_pos;

   assign out_code = to_twos(sar_code_q); // see RQ6
   assign next_pos = fall_cnt_q + CNT_ONE;
   assign res_pos = next_pos - ZERO_LEN;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_result_out <= 1'b0;
         serial_result_oe <= 1'b0;
      end
      else if (fs_high)
      begin
         serial_result_out <= 1'b0;
         serial_result_oe <= 1'b0; // see RQ2, RQ13
      end
      else if (state_q == SARRD_IDLE && fs_fall)
      begin
         serial_result_out <= 1'b0; // see RQ4
         serial_result_oe <= 1'b1; // see RQ2
      end
      else if (sck_fall && state_q != SARRD_IDLE && fall_cnt_q != FRAME_LEN)
      begin
         if (next_pos < ZERO_LEN)
         begin
            serial_result_out <= 1'b0; // see RQ4
         end
         else if (next_pos < FRAME_LEN)
         begin
            serial_result_out <= out_code[RES_W-1-res_pos[BIT_W-1:0]]; // see RQ5
         end
         else
         begin
            serial_result_out <= 1'b0;
         end
      end
   end

endmodule

// ### testbench/sarrd_chk_sva.sv
`timescale 1ns/1ps
module sarrd_chk
   import sarrd_pkg::*;
#(
   parameter int RES_W = RES_BITS
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic frame_sel_n,
   input wire logic serial_clk,
   input wire logic comp_above,
   input wire logic [RES_W-1:0] dac_trial_code,
   input wire logic track_hold,
   input wire logic serial_result_out,
   input wire logic serial_result_oe,
   input wire logic [RES_W-1:0] conv_result,
   input wire logic conv_done
);
   logic sclk_q;
   logic [4:0] falls_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // serial clock falls seen in the current frame
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_q <= 1'b1;
         falls_q <= 5'h00;
      end
      else
      begin
         sclk_q <= serial_clk;
         if (frame_sel_n)
            falls_q <= 5'h00;
         else if (sclk_q && !serial_clk)
            falls_q <= falls_q + 5'h01;
      end
   end
   sequence s_open;
      $fell(frame_sel_n);
   endsequence
   sequence s_step;
      serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out);
   endsequence
   chk_oe_open:
   assert property (s_open |-> ##4 serial_result_oe && !serial_result_out) else $error("oe late");
   chk_hold_open:
   assert property (s_open |-> ##4 track_hold) else $error("hold late");
   chk_oe_close:
   assert property ($rose(frame_sel_n) |-> ##4 !serial_result_oe) else $error("oe stuck");
   chk_oe_quiet:
   assert property (!serial_result_oe |-> !serial_result_out) else $error("data off frame");
   chk_lead_zero:
   assert property (serial_result_oe && !frame_sel_n && falls_q < ZERO_LEN |-> !serial_result_out)
      else $error("lead not zero");
   chk_bit_step:
   assert property (s_step |-> $past(serial_clk, 6) && !$past(serial_clk, 3))
      else $error("data off edge");
   chk_done_pulse:
   assert property (conv_done |=> !conv_done) else $error("done too long");
   chk_done_late:
   assert property (conv_done |-> falls_q >= 5'h0e && falls_q <= 5'h0f) else $error("done time");
   chk_hold_drop:
   assert property (conv_done |-> track_hold ##1 !track_hold) else $error("hold drop");
   chk_result_done:
   assert property ($changed(conv_result) |-> conv_done) else $error("result no done");
endmodule
bind sarrd_top sarrd_chk #(.RES_W(RES_W)) sarrd_chk_i (.mclk(mclk), .rst_n(rst_n),
   .frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .comp_above(comp_above),
   .dac_trial_code(dac_trial_code), .track_hold(track_hold),
   .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
   .conv_result(conv_result), .conv_done(conv_done));

// ### testbench/sarrd_host.sv
`timescale 1ns/1ps
module sarrd_host
(
   input wire logic mclk,
   output logic frame_sel_n,
   output logic serial_clk,
   input wire logic serial_result_out,
   input wire logic serial_result_oe
);
   initial
   begin
      frame_sel_n = 1'b1;
      serial_clk = 1'b1;
   end
   // released pin reads as unknown
   task automatic run_frame(input int periods, output logic [15:0] word);
      @(posedge mclk);
      frame_sel_n <= 1'b0;
      repeat (8) @(posedge mclk);
      word[15] = serial_result_oe ? serial_result_out : 1'bx;
      for (int k = 1; k <= periods; k++)
      begin
         serial_clk <= 1'b0;
         repeat (4) @(posedge mclk);
         serial_clk <= 1'b1;
         repeat (3) @(posedge mclk);
         if (k < 16)
            word[15-k] = serial_result_oe ? serial_result_out : 1'bx;
         @(posedge mclk);
      end
      frame_sel_n <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask
endmodule

// ### testbench/sarrd_top_tb_top.sv
`timescale 1ns/1ps
module sarrd_top_tb_top
   import sarrd_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic comp_above = 1'b0;
   logic frame_sel_n, serial_clk, track_hold, serial_result_out, serial_result_oe, conv_done;
   logic [RES_BITS-1:0] dac_trial_code, conv_result;
   logic [RES_BITS-1:0] level = 12'h000;
   logic [15:0] word;
   int num_errors = 0;
   int compares = 0;
   int done_cnt = 0;
   always #10 mclk = ~mclk;
   // comparator: input half a step above level
   always @(posedge mclk) comp_above <= ({level, 1'b1} > {dac_trial_code, 1'b0});
   always @(posedge mclk) if (conv_done === 1'b1) done_cnt++;
   sarrd_top sarrd_top_i (.mclk(mclk), .rst_n(rst_n), .frame_sel_n(frame_sel_n),
      .serial_clk(serial_clk), .comp_above(comp_above), .dac_trial_code(dac_trial_code),
      .track_hold(track_hold), .serial_result_out(serial_result_out),
      .serial_result_oe(serial_result_oe), .conv_result(conv_result), .conv_done(conv_done));
   sarrd_host sarrd_host_i (.mclk(mclk), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
      .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));
   ////////////////////////////////////////
   task automatic check_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////
   task automatic test_idle();
      check_bit("idle oe", 1'b0, serial_result_oe);
      check_bit("idle hold", 1'b0, track_hold);
      $display("test_idle done");
   endtask
   task automatic test_codes();
      logic [11:0] lv [6] = '{12'hfff, 12'h000, 12'h7ff, 12'h800, 12'h7fe, 12'h5a3};
      int d0;
      for (int i = 0; i < 6; i++)
      begin
         level <= lv[i];
         d0 = done_cnt;
         sarrd_host_i.run_frame(16, word);
         check_vec("word", {4'h0, lv[i] ^ 12'h800}, word);
         check_vec("result", {4'h0, lv[i] ^ 12'h800}, {4'h0, conv_result});
         check_vec("done", 16'h0001, 16'(done_cnt - d0));
      end
      $display("test_codes done");
   endtask
   task automatic test_abort();
      logic [11:0] keep;
      int d0;
      keep = conv_result;
      d0 = done_cnt;
      level <= 12'h3c3;
      sarrd_host_i.run_frame(8, word);
      @(negedge mclk);
      check_vec("abort result", {4'h0, keep}, {4'h0, conv_result});
      check_vec("abort done", 16'h0000, 16'(done_cnt - d0));
      check_bit("abort oe", 1'b0, serial_result_oe);
      check_vec("abort bits", 16'h000b, {8'h00, word[15:8]});
      @(posedge mclk);
      level <= 12'h001;
      sarrd_host_i.run_frame(16, word);
      check_vec("after abort", 16'h0801, word);
      $display("test_abort done");
   endtask
   initial
   begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      test_idle();
      test_codes();
      test_abort();
      summarize();
   end
   initial
   begin
      #400000;
      num_errors++;
      $display("watchdog expired");
      summarize();
   end
endmodule
